/* File: pb_window_decode_page_translate_tb.sv */
// self-checking bench for the window decoder and page translation
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((e) !== (g)) begin \
  errorCnt++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pb_window_decode_page_translate_tb;
  logic mclk, rst_n, mode36Strap, pbValid, pbWrite, pbClaim;
  logic fabValid, wrProtErr, avsRead, avsWrite, avsWaitRequest;
  logic [35:0] pbAddr, a;
  logic [11:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, fabCount;
  logic [31:0] lut [8];
  logic [31:0] upv [8];
  logic [3:0] avsByteEnable, lastDest;
  pwdpt_pkg::pwdpt_fab_req_t fabReq;
  logic [71:0] expFab [$];
  logic [31:0] expRd [$];
  int errorCnt, nCompared, seed, nFwd;

  pwdpt_window_decode u_dut (.mclk(mclk), .rst_n(rst_n),
    .mode36Strap(mode36Strap), .pbValid(pbValid), .pbAddr(pbAddr),
    .pbWrite(pbWrite), .pbClaim(pbClaim), .fabValid(fabValid),
    .fabReq(fabReq), .wrProtErr(wrProtErr), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest));
  pwdpt_fabric_model u_fabric (.mclk(mclk), .rst_n(rst_n),
    .fabValid(fabValid), .fabReq(fabReq), .fabCount(fabCount),
    .lastDest(lastDest));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [35:0] rnd();
    logic [31:0] r0, r1;
    r0 = $random(seed);
    r1 = $random(seed);
    return {r1[3:0], r0};
  endfunction

  // page base from the tables, offset below the page shift from the bus
  function automatic logic [63:0] xl(input logic [31:0] up,
      input logic [31:0] lo, input logic [35:0] ad, input int sh);
    logic [63:0] m;
    m = (64'h1 << sh) - 64'h1;
    return ({up, lo[31:23], 23'h0} & ~m) | ({28'h0, ad} & m);
  endfunction

  function automatic logic [71:0] fe(input int i, input logic [35:0] ad,
      input int sh, input logic wr);
    return {wr & lut[i][5], xl(upv[i], lut[i], ad, sh), lut[i][3:0],
      lut[i][7:6], wr};
  endfunction

  function automatic logic [71:0] fb(input logic [35:0] ad);
    return {1'b0, 44'h0, ad[19:0], 4'h0, 2'b10, 1'b0};
  endfunction

  task automatic avs(input logic rd, input logic [11:0] ad,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    pbValid <= 1'b0;
    avsAddress <= ad;
    avsWriteData <= d;
    avsRead <= rd;
    avsWrite <= !rd;
    if (rd) expRd.push_back(d);
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    `CHK("avsWaitRequest", 1'b0, avsWaitRequest)
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic pb(input logic [35:0] ad, input logic wr, input logic clm,
      input logic [71:0] e);
    @(posedge mclk);
    pbAddr <= ad;
    pbWrite <= wr;
    pbValid <= 1'b1;
    // the bus carries no size, so no access touches split bytes
    #1;
    `CHK("pbClaim", clm, pbClaim)
    if (clm) expFab.push_back(e);
    if (clm && !e[71]) nFwd++;
  endtask

  task automatic done(input string t);
    $display("test %s done", t);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // result monitor: oldest note is compared with each result seen
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    logic [71:0] e;
    if (fabValid === 1'b1 || wrProtErr === 1'b1) begin
      e = (expFab.size() > 0) ? expFab.pop_front() : 'x;
      `CHK("wrProtErr", e[71], wrProtErr)
      `CHK("fabValid", !e[71], fabValid)
      if (!e[71]) `CHK("fabReq", e[70:0], fabReq)
    end
    if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
      e[31:0] = (expRd.size() > 0) ? expRd.pop_front() : 'x;
      `CHK("avsReadData", e[31:0], avsReadData)
    end
  end

  // a hung handshake ends the run through the common closing task
  initial begin
    #40000;
    errorCnt++;
    report_and_stop();
  end

  initial begin
    seed = 67;
    errorCnt = 0;
    nCompared = 0;
    nFwd = 0;
    rst_n = 1'b0;
    mode36Strap = 1'b0;
    pbValid = 1'b0;
    pbAddr = 36'h0;
    pbWrite = 1'b0;
    avsAddress = 12'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hF;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    avs(1'b1, 12'h414, 32'hF000_0003);
    avs(1'b1, 12'h418, 32'h0);
    avs(1'b1, 12'h000, 32'h0);
    done("reset");
    a = rnd();
    a[31:28] = 4'hF;
    pb(a, 1'b0, 1'b1, fb(a));
    pb(a, 1'b1, 1'b1, {1'b1, 71'h0});
    pb(36'h0_1000_0000, 1'b0, 1'b0, 72'h0);
    done("boot");
    // upper base 5 must be ignored with 32-bit addressing
    avs(1'b0, 12'h418, 32'h2500_0001);
    for (int i = 0; i < 8; i++) begin
      lut[i] = {9'(i * 37 + 5), 15'h0, 2'(i), i[2], 1'b1, 4'(i)};
      upv[i] = $random(seed);
      avs(1'b0, 12'h900 + 12'(32 * i + 24), lut[i]);
      avs(1'b0, 12'h904 + 12'(32 * i + 24), upv[i]);
      avs(1'b1, 12'h900 + 12'(32 * i + 24), lut[i]);
      a = rnd();
      a[31:28] = 4'h2;
      a[27:23] = 5'(4 * i + 3);
      pb(a, 1'b0, 1'b1, fe(i, a, 23, 1'b0));
      pb(a, 1'b1, 1'b1, fe(i, a, 23, 1'b1));
    end
    avs(1'b0, 12'h418, 32'h2500_0000);
    pb(a, 1'b0, 1'b0, 72'h0);
    done("pages");
    for (int s = 0; s < 5; s++) begin
      avs(1'b0, 12'h418, 32'h1 | (32'(s) << 8));
      a = (rnd() & ~({36{1'b1}} << (23 + s))) | (36'h7 << (23 + s));
      pb(a, 1'b0, 1'b1, fe(1, a, 23 + s, 1'b0));
      a = a | 36'h0_8000_0000;
      pb(a, 1'b0, s == 4, fe(5, a, 27, 1'b0));
    end
    done("sizes");
    // drop the last request before the mode changes under it
    @(posedge mclk);
    pbValid <= 1'b0;
    mode36Strap <= 1'b1;
    repeat (4) @(posedge mclk);
    avs(1'b1, 12'h41C, 32'h3);
    avs(1'b0, 12'h41C, 32'h1);
    avs(1'b1, 12'h41C, 32'h2);
    avs(1'b0, 12'h418, 32'h1100_0001);
    avs(1'b0, 12'h900, 32'h1100_0014);
    avs(1'b0, 12'h904, 32'h0000_000E);
    pb(36'h1_1070_0010, 1'b0, 1'b1,
      {1'b0, 64'hE_1170_0010, 4'h4, 2'b00, 1'b0});
    pb(36'h2_1070_0010, 1'b0, 1'b0, 72'h0);
    a = rnd();
    a[35:28] = 8'h0F;
    pb(a, 1'b0, 1'b1, fb(a));
    avs(1'b0, 12'h900, 32'h0000_0045);
    avs(1'b0, 12'h418, 32'h0000_0801);
    a = rnd() & 36'h0_0FFF_FFFF;
    pb(a, 1'b1, 1'b1, {1'b0, 28'h0, a, 4'h5, 2'b01, 1'b1});
    // wide sizes keep page 0; code 9 is out of range and never hits
    for (int s = 5; s < 10; s++) begin
      avs(1'b0, 12'h418, 32'h1 | (32'(s) << 8));
      a = rnd() & ((36'h1 << (23 + s)) - 36'h1) & 36'h0_7FFF_FFFF;
      pb(a, 1'b0, s < 9, {1'b0, 28'h0, a, 4'h5, 2'b01, 1'b0});
      a[35] = 1'b1;
      if (s != 8) pb(a, 1'b0, 1'b0, 72'h0);
    end
    done("wide");
    avs(1'b0, 12'h418, 32'h0);
    // low byte only: enable cleared, boot bit and base kept
    avsByteEnable <= 4'h1;
    avs(1'b0, 12'h414, 32'h0000_0002);
    avsByteEnable <= 4'hF;
    avs(1'b1, 12'h414, 32'hF000_0002);
    a[35:28] = 8'h0F;
    pb(a, 1'b0, 1'b0, 72'h0);
    done("disable");
    @(posedge mclk);
    pbValid <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("fabCount", 32'(nFwd), fabCount)
    `CHK("lastDest", 4'h5, lastDest)
    `CHK("pending", 0, expFab.size() + expRd.size())
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: pwdpt_fabric_model.sv */
// switch fabric sink that accepts and counts forwarded requests
`timescale 1ns/1ps
`default_nettype none
module pwdpt_fabric_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fabValid,
  input wire pwdpt_pkg::pwdpt_fab_req_t fabReq,
  output logic [31:0] fabCount,
  output logic [3:0] lastDest
);
  // the fabric never stalls: the decoder has no back-pressure input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fabCount <= 32'h0;
      lastDest <= 4'h0;
    end else if (fabValid) begin
      fabCount <= fabCount + 32'h1;
      lastDest <= fabReq.dest;
    end
  end
endmodule
`default_nettype wire

/* File: pwdpt_pkg.sv */
// constants, field layouts and carrier types for the window decoder
//
// How it works
// - window base field matches A[4:7] in 36-bit mode, A[0:3] in 32-bit
// - upper base field matches A[0:3] in 36-bit mode, ignored in 32-bit
// - a window produces hits only while its enable bit is set
// - window one resets enabled, booting from host port, value F000_0003
// - window two resets to all zeros, hence disabled
// - 36-bit size codes 0-8 give 256M to 64G windows, 8M to 2G pages
// - 32-bit size codes 0-4 give 256M to 4G windows, index shifts up
// - five page-index bits pick one of 32 table entries of the window
// - 32-bit addressing with size 0100 claims every address
// - 36-bit addressing with size 1000 claims every address
// - translation on: entry bits 31:23 replace matching address bits
// - translation on: translation field overwrites the forwarded address above the page offset; offset bits pass through
// - endian field: none, address-based, byte swap, word halves swap
// - write into a write-protected page is flagged as an error
// - entry destination field names the fabric port that receives it
// - destination codes: host port, pci, cpu master/slave, mem, dma, eth
// - translation on: upper entry supplies address bits 63:32
// - boot bit: host port, all protected, no tables, byte swap, low offset
package pwdpt_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_WIN_ONE = 12'h414;
  localparam logic [11:0] OFF_WIN_TWO = 12'h418;
  localparam logic [11:0] OFF_STATUS = 12'h41C;
  localparam logic [3:0] LUT_ONE_PAGE = 4'h8;
  localparam logic [3:0] LUT_TWO_PAGE = 4'h9;

  // ----------------------------------------------------------------------
  // window register fields
  // ----------------------------------------------------------------------
  localparam int WIN_BA_LSB = 28;
  localparam int WIN_UP_LSB = 24;
  localparam int WIN_SIZE_LSB = 8;
  localparam int WIN_BOOT_BIT = 1;
  localparam int WIN_EN_BIT = 0;
  localparam logic [31:0] WIN_ONE_RST = 32'hF000_0003;
  localparam logic [31:0] WIN_TWO_RST = 32'h0000_0000;
  localparam logic [3:0] SIZE_ALL_32 = 4'h4;
  localparam logic [3:0] SIZE_ALL_36 = 4'h8;

  // ----------------------------------------------------------------------
  // lower table entry fields
  // ----------------------------------------------------------------------
  localparam int LO_TA_LSB = 23;
  localparam int LO_END_LSB = 6;
  localparam int LO_WP_BIT = 5;
  localparam int LO_ATE_BIT = 4;
  localparam int LO_DST_LSB = 0;
  localparam logic [5:0] PAGE_SHIFT_BASE = 6'h17;
  localparam int BOOT_OFS_W = 20;

  // status register fields
  localparam int ST_WPERR_BIT = 0;
  localparam int ST_MODE36_BIT = 1;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    END_NONE = 2'b00,
    END_ADDR = 2'b01,
    END_BYTE = 2'b10,
    END_WORD = 2'b11
  } pwdpt_endian_t;

  typedef enum logic [3:0] {
    DST_HOST_LOCAL = 4'b0000,
    DST_PCIX = 4'b0001,
    DST_CPU_MASTER = 4'b0010,
    DST_CPU_SLAVE = 4'b0011,
    DST_MEMORY = 4'b0100,
    DST_DMA = 4'b0101,
    DST_ETHERNET = 4'b0110,
    DST_RESERVED = 4'b0111
  } pwdpt_dest_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [3:0] dest;
    pwdpt_endian_t endian;
    logic write;
  } pwdpt_fab_req_t;

endpackage

/* File: pwdpt_window_decode.sv */
// processor-bus window decoder with per-page lookup and translation
`timescale 1ns/1ps
`default_nettype none
module pwdpt_window_decode (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mode36Strap,
  input wire logic pbValid,
  input wire logic [35:0] pbAddr,
  input wire logic pbWrite,
  output logic pbClaim,
  output logic fabValid,
  output pwdpt_pkg::pwdpt_fab_req_t fabReq,
  output logic wrProtErr,
  input wire logic [11:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest
);

  // ----------------------------------------------------------------------
  // reset and strap synchronisers
  // ----------------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_n;
  logic modeMeta_r;
  logic mode36_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // strap is a pin: two flops before any decode reads it
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      modeMeta_r <= 1'b0;
      mode36_r <= 1'b0;
    end else begin
      modeMeta_r <= mode36Strap;
      mode36_r <= modeMeta_r;
    end
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic winHit(input logic [31:0] w,
                                  input logic [35:0] a,
                                  input logic m36);
    logic [3:0] sz;
    logic [7:0] diff;
    logic hit;
    sz = w[pwdpt_pkg::WIN_SIZE_LSB +: 4];
    hit = 1'b0;
    if (m36) begin
      // upper field joins the compare only in 36-bit mode
      diff = a[35:28] ^ {w[pwdpt_pkg::WIN_UP_LSB +: 4],
                         w[pwdpt_pkg::WIN_BA_LSB +: 4]};
      if (sz <= pwdpt_pkg::SIZE_ALL_36) begin
        hit = (diff >> sz) == 8'h00;
      end
    end else begin
      diff = {4'h0, a[31:28] ^ w[pwdpt_pkg::WIN_BA_LSB +: 4]};
      if (sz <= pwdpt_pkg::SIZE_ALL_32) begin
        hit = (diff >> sz) == 8'h00;
      end
    end
    return w[pwdpt_pkg::WIN_EN_BIT] && hit;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------------
  logic [31:0] winOne_r;
  logic [31:0] winTwo_r;
  logic wpErrSticky_r;
  // tables are plain memories: contents are undefined until programmed
  logic [31:0] lutLo [2][32];
  logic [31:0] lutHi [2][32];

  // ----------------------------------------------------------------------
  // register bus slave: one wait state on every access
  // ----------------------------------------------------------------------
  logic busAck_r;
  logic busReq;
  logic busWr;
  logic isLut;
  logic lutWin;
  logic [4:0] lutIdx;
  logic lutUpper;

  assign busReq = avsRead || avsWrite;
  assign avsWaitRequest = busReq && !busAck_r;
  assign busWr = avsWrite && busAck_r;
  assign isLut = (avsAddress[11:8] == pwdpt_pkg::LUT_ONE_PAGE) ||
                 (avsAddress[11:8] == pwdpt_pkg::LUT_TWO_PAGE);
  assign lutWin = avsAddress[8];
  assign lutIdx = avsAddress[7:3];
  assign lutUpper = avsAddress[2];

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      busAck_r <= 1'b0;
    end else begin
      busAck_r <= busReq && !busAck_r;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      winOne_r <= pwdpt_pkg::WIN_ONE_RST;
      winTwo_r <= pwdpt_pkg::WIN_TWO_RST;
    end else if (busWr) begin
      if (avsAddress == pwdpt_pkg::OFF_WIN_ONE) begin
        winOne_r <= byteMerge(winOne_r, avsWriteData, avsByteEnable);
      end
      if (avsAddress == pwdpt_pkg::OFF_WIN_TWO) begin
        winTwo_r <= byteMerge(winTwo_r, avsWriteData, avsByteEnable);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (busWr && isLut) begin
      if (lutUpper) begin
        lutHi[lutWin][lutIdx] <= byteMerge(lutHi[lutWin][lutIdx],
                                           avsWriteData, avsByteEnable);
      end else begin
        lutLo[lutWin][lutIdx] <= byteMerge(lutLo[lutWin][lutIdx],
                                           avsWriteData, avsByteEnable);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead && !busAck_r) begin
      if (avsAddress == pwdpt_pkg::OFF_WIN_ONE) begin
        avsReadData <= winOne_r;
      end else if (avsAddress == pwdpt_pkg::OFF_WIN_TWO) begin
        avsReadData <= winTwo_r;
      end else if (avsAddress == pwdpt_pkg::OFF_STATUS) begin
        avsReadData <= 32'h0000_0000;
        avsReadData[pwdpt_pkg::ST_WPERR_BIT] <= wpErrSticky_r;
        avsReadData[pwdpt_pkg::ST_MODE36_BIT] <= mode36_r;
      end else if (isLut) begin
        avsReadData <= lutUpper ? lutHi[lutWin][lutIdx]
                                : lutLo[lutWin][lutIdx];
      end else begin
        avsReadData <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transaction decode
  // ----------------------------------------------------------------------
  logic [35:0] effAddr;
  logic hitOne;
  logic hitTwo;
  logic anyHit;
  logic selTwo;
  logic bootSel;
  logic [3:0] selSize;
  logic [5:0] pageShift;
  logic [4:0] pageIdx;
  logic [31:0] entLo;
  logic [31:0] entHi;
  logic [63:0] offMask;
  logic [63:0] xlatBase;
  logic wpHit;
  pwdpt_pkg::pwdpt_fab_req_t reqNxt;

  always_comb begin
    // 32-bit masters never drive the four top address bits
    effAddr = mode36_r ? pbAddr : {4'h0, pbAddr[31:0]};
    hitOne = winHit(winOne_r, effAddr, mode36_r);
    hitTwo = winHit(winTwo_r, effAddr, mode36_r);
    anyHit = hitOne || hitTwo;
    // window one wins when both windows overlap
    selTwo = !hitOne;
    bootSel = hitOne && winOne_r[pwdpt_pkg::WIN_BOOT_BIT];
    selSize = selTwo ? winTwo_r[pwdpt_pkg::WIN_SIZE_LSB +: 4]
                     : winOne_r[pwdpt_pkg::WIN_SIZE_LSB +: 4];
    pageShift = pwdpt_pkg::PAGE_SHIFT_BASE + {2'b00, selSize};
    pageIdx = 5'(effAddr >> pageShift);
    entLo = lutLo[selTwo][pageIdx];
    entHi = lutHi[selTwo][pageIdx];
    offMask = (64'h1 << pageShift) - 64'h1;
    xlatBase = {entHi, entLo[31:pwdpt_pkg::LO_TA_LSB], 23'h000000};
    reqNxt.write = pbWrite;
    if (bootSel) begin
      reqNxt.addr = {44'h0, effAddr[pwdpt_pkg::BOOT_OFS_W-1:0]};
      reqNxt.dest = pwdpt_pkg::DST_HOST_LOCAL;
      reqNxt.endian = pwdpt_pkg::END_BYTE;
      wpHit = 1'b1;
    end else begin
      if (entLo[pwdpt_pkg::LO_ATE_BIT]) begin
        reqNxt.addr = (xlatBase & ~offMask) | ({28'h0, effAddr} & offMask);
      end else begin
        reqNxt.addr = {28'h0, effAddr};
      end
      reqNxt.dest = entLo[pwdpt_pkg::LO_DST_LSB +: 4];
      reqNxt.endian = pwdpt_pkg::pwdpt_endian_t'(
        entLo[pwdpt_pkg::LO_END_LSB +: 2]);
      wpHit = entLo[pwdpt_pkg::LO_WP_BIT];
    end
  end

  assign pbClaim = pbValid && anyHit;

  // ----------------------------------------------------------------------
  // fabric request register
  // ----------------------------------------------------------------------
  logic protViol;
  assign protViol = pbClaim && pbWrite && wpHit;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fabValid <= 1'b0;
      wrProtErr <= 1'b0;
    end else begin
      // a refused write is not passed on to the fabric
      fabValid <= pbClaim && !protViol;
      wrProtErr <= protViol;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fabReq <= '0;
    end else if (pbClaim) begin
      fabReq <= reqNxt;
    end
  end

  // sticky error: a new violation in the clearing cycle wins
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wpErrSticky_r <= 1'b0;
    end else if (protViol) begin
      wpErrSticky_r <= 1'b1;
    end else if (busWr && avsAddress == pwdpt_pkg::OFF_STATUS &&
                 avsByteEnable[0] && avsWriteData[pwdpt_pkg::ST_WPERR_BIT]) begin
      wpErrSticky_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_reset_win_one;
    @(posedge mclk) $rose(rstSync_n) |-> winOne_r == pwdpt_pkg::WIN_ONE_RST;
  endproperty
  a_reset_win_one: assert property (p_reset_win_one)
    else $error("window one reset value wrong");

  property p_reset_win_two;
    @(posedge mclk) $rose(rstSync_n) |-> !winTwo_r[pwdpt_pkg::WIN_EN_BIT];
  endproperty
  a_reset_win_two: assert property (p_reset_win_two)
    else $error("window two enabled after reset");

  property p_disabled_no_fwd;
    @(posedge mclk) disable iff (!rstSync_n)
      pbValid && !winOne_r[pwdpt_pkg::WIN_EN_BIT] &&
      !winTwo_r[pwdpt_pkg::WIN_EN_BIT] |-> !pbClaim ##1 !fabValid;
  endproperty
  a_disabled_no_fwd: assert property (p_disabled_no_fwd)
    else $error("disabled windows produced a hit");

  property p_miss_no_fwd;
    @(posedge mclk) disable iff (!rstSync_n)
      !pbClaim |=> !fabValid && !wrProtErr;
  endproperty
  a_miss_no_fwd: assert property (p_miss_no_fwd)
    else $error("unclaimed transaction forwarded");

  property p_claim_all_32;
    @(posedge mclk) disable iff (!rstSync_n)
      pbValid && !mode36_r && winTwo_r[pwdpt_pkg::WIN_EN_BIT] &&
      winTwo_r[pwdpt_pkg::WIN_SIZE_LSB +: 4] == pwdpt_pkg::SIZE_ALL_32
      |-> pbClaim;
  endproperty
  a_claim_all_32: assert property (p_claim_all_32)
    else $error("size 0100 did not claim in 32-bit mode");

  property p_claim_all_36;
    @(posedge mclk) disable iff (!rstSync_n)
      pbValid && mode36_r && winTwo_r[pwdpt_pkg::WIN_EN_BIT] &&
      winTwo_r[pwdpt_pkg::WIN_SIZE_LSB +: 4] == pwdpt_pkg::SIZE_ALL_36
      |-> pbClaim;
  endproperty
  a_claim_all_36: assert property (p_claim_all_36)
    else $error("size 1000 did not claim in 36-bit mode");

  property p_boot_route;
    @(posedge mclk) disable iff (!rstSync_n)
      pbClaim && bootSel && !pbWrite |=> fabValid &&
      fabReq.dest == pwdpt_pkg::DST_HOST_LOCAL &&
      fabReq.endian == pwdpt_pkg::END_BYTE && fabReq.addr[63:20] == 44'h0;
  endproperty
  a_boot_route: assert property (p_boot_route)
    else $error("boot access not routed to host port");

  property p_write_protect;
    @(posedge mclk) disable iff (!rstSync_n)
      pbClaim && pbWrite && (bootSel || entLo[pwdpt_pkg::LO_WP_BIT])
      |=> wrProtErr && !fabValid ##1 wpErrSticky_r;
  endproperty
  a_write_protect: assert property (p_write_protect)
    else $error("protected write not flagged");

  property p_xlat_upper;
    @(posedge mclk) disable iff (!rstSync_n)
      pbClaim && !bootSel && entLo[pwdpt_pkg::LO_ATE_BIT] && !pbWrite
      |=> fabReq.addr[63:32] == $past(entHi) &&
      fabReq.dest == $past(entLo[3:0]) &&
      fabReq.endian == $past(entLo[7:6]);
  endproperty
  a_xlat_upper: assert property (p_xlat_upper)
    else $error("translated request fields wrong");

  property p_no_xlat;
    @(posedge mclk) disable iff (!rstSync_n)
      pbClaim && !bootSel && !entLo[pwdpt_pkg::LO_ATE_BIT]
      |=> fabReq.addr[35:0] == $past(effAddr);
  endproperty
  a_no_xlat: assert property (p_no_xlat)
    else $error("untranslated address altered");

  c_boot_read: cover property (@(posedge mclk) pbClaim && bootSel ##1 fabValid);
  c_xlat_fwd: cover property (@(posedge mclk)
    pbClaim && !bootSel && entLo[pwdpt_pkg::LO_ATE_BIT] ##1 fabValid);
  c_wp_error: cover property (@(posedge mclk) wrProtErr);
  c_bus_write: cover property (@(posedge mclk) busWr && isLut);

endmodule
`default_nettype wire
